/* File: adc_spi_register_access.sv */
// Contract
// RULE_01: host gives at least 16 serial clocks after each chip-select fall.
// RULE_02: input bits 15..9 are the register address, bit 8 read/write.
// RULE_03: on a write, bits 7..0 are stored into the addressed register; code: 0Ch keeps all 8 bits, 01h is not stored, others clear unused bits.
// RULE_04: on a read, bits 7..0 ignored; register content shifted out msb first.
// RULE_05: a written command takes effect at the next chip-select falling edge.
// RULE_06: power-down write takes effect right at the 16th serial clock fall; code: once the toggle set at the 16th rise has crossed to ref_clk_in.
// RULE_07: two pages; page 0 after power-up and reset addresses page-0 registers.
// RULE_08: writing 01h to address 7Fh selects page 1 for later accesses.
// RULE_09: page 0 holds sequencing and configuration; page 1 holds thresholds; code: no threshold registers, page-1 writes other than 7Fh are dropped.
// RULE_10: an all-zero frame changes nothing; last sequencing mode continues.
// RULE_11: manual register 04h: channel bits 6..4, range 3..1, temp bit 0.
// RULE_12: serial input sampled on every rising serial clock edge.
// RULE_13: output shifts on falling edges, released after 16 bits or cs high.
// RULE_14: all registers return to defaults at power-on and on soft reset.
// RULE_15: read/write bit: 1 means write, 0 means read.
`timescale 1ns/100ps
`default_nettype none
module adc_spi_register_access
  import adc_spi_regs_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       din_in,
  output var  logic       dout_out,
  output var  logic       dout_oe_out,
  output var  logic [7:0] manual_sequence_control_out,
  output var  logic [7:0] auto_sequence_control_out,
  output var  logic [7:0] auxiliary_configuration_out,
  output var  logic [7:0] auto_scan_channel_mask_out,
  output var  logic [7:0] range_select_pair_a_out,
  output var  logic [7:0] range_select_pair_b_out,
  output var  logic       page_select_out,
  output var  logic       power_down_out,
  output var  logic       auto_mode_out,
  output var  logic       seq_restart_out
);

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // ---------------- link side, serial clock domain ----------------
  // the frame logic is held in reset while chip select is high, so no
  // serial clock edge outside a frame is ever counted
  logic        frame_rst_n;
  logic [4:0]  rise_cnt;
  logic [14:0] in_shift;
  logic [15:0] cmd_word;
  logic        wr_toggle;
  logic [4:0]  fall_cnt;
  logic [6:0]  out_shift;
  logic [7:0]  rd_data;

  assign frame_rst_n = rst_n_in & ~cs_n_in;

  always_ff @(posedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rise_cnt <= 5'd0;
      in_shift <= 15'h0000;
    end else if (rise_cnt < 5'd16) begin
      rise_cnt <= rise_cnt + 5'd1;
      in_shift <= {in_shift[13:0], din_in};                   // see RULE_12
    end
  end

  // the completed word survives chip select high; the register side
  // reads it only after the toggle has crossed
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_word  <= 16'h0000;
      wr_toggle <= 1'b0;
    end else if (frame_rst_n && rise_cnt == LAST_EDGE) begin
      cmd_word <= {in_shift, din_in};                         // see RULE_02
      if (in_shift[ADDR_LSB-2] == RW_WRITE) begin             // see RULE_15
        wr_toggle <= ~wr_toggle;
      end
    end
  end

  always_ff @(negedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fall_cnt    <= 5'd0;
      dout_out    <= 1'b0;
      dout_oe_out <= 1'b0;
      out_shift   <= 7'h00;
    end else if (fall_cnt < 5'd16) begin
      fall_cnt    <= fall_cnt + 5'd1;
      dout_oe_out <= (fall_cnt != LAST_EDGE);                 // see RULE_13
      if (fall_cnt == RD_LOAD_EDGE && in_shift[0] == RW_READ) begin
        dout_out  <= rd_data[7];                              // see RULE_04
        out_shift <= rd_data[6:0];
      end else begin
        dout_out  <= out_shift[6];                            // see RULE_13
        out_shift <= {out_shift[5:0], 1'b0};
      end
    end
  end

  // ---------------- register side, reference clock domain ----------------
  logic [SYNC_STAGES:0] cs_sync;
  logic [SYNC_STAGES:0] tog_sync;
  logic                 cs_fall;
  logic                 tog_edge;
  logic                 pending;
  logic                 apply;
  logic [6:0]           cmd_addr;
  logic [7:0]           cmd_data;
  logic                 soft_reset;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_sync  <= '1;
      tog_sync <= '0;
    end else begin
      cs_sync  <= {cs_sync[SYNC_STAGES-1:0], cs_n_in};
      tog_sync <= {tog_sync[SYNC_STAGES-1:0], wr_toggle};
    end
  end

  assign cs_fall  = cs_sync[SYNC_STAGES] & ~cs_sync[SYNC_STAGES-1];
  assign tog_edge = tog_sync[SYNC_STAGES] ^ tog_sync[SYNC_STAGES-1];
  assign cmd_addr = cmd_word[ADDR_MSB:ADDR_LSB];
  assign cmd_data = cmd_word[DATA_MSB:DATA_LSB];
  assign apply    = pending & cs_fall;
  assign soft_reset = apply && !page_select_out
                   && cmd_addr == ADDR_DEVICE_SOFT_RESET
                   && cmd_data[SOFT_RESET_BIT];

  // a frame that completes in the same cycle as an apply stays pending
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pending <= 1'b0;
    end else if (tog_edge) begin
      pending <= 1'b1;
    end else if (cs_fall) begin
      pending <= 1'b0;                                        // see RULE_05
    end
  end

  function automatic logic page0_hit(input logic [6:0] a,
                                     input logic [6:0] want);
    return apply && !page_select_out && a == want;
  endfunction

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      manual_sequence_control_out <= RST_MANUAL_SEQUENCE_CTRL;
      auto_sequence_control_out   <= RST_AUTO_SEQUENCE_CTRL;
      auxiliary_configuration_out <= RST_AUXILIARY_CONFIG;
      auto_scan_channel_mask_out  <= RST_AUTO_SCAN_MASK;
      range_select_pair_a_out     <= RST_RANGE_PAIR;
      range_select_pair_b_out     <= RST_RANGE_PAIR;
    end else if (soft_reset) begin                            // see RULE_14
      manual_sequence_control_out <= RST_MANUAL_SEQUENCE_CTRL;
      auto_sequence_control_out   <= RST_AUTO_SEQUENCE_CTRL;
      auxiliary_configuration_out <= RST_AUXILIARY_CONFIG;
      auto_scan_channel_mask_out  <= RST_AUTO_SCAN_MASK;
      range_select_pair_a_out     <= RST_RANGE_PAIR;
      range_select_pair_b_out     <= RST_RANGE_PAIR;
    end else begin
      // writes on page 1 target thresholds not held here and are dropped
      if (page0_hit(cmd_addr, ADDR_MANUAL_SEQUENCE_CTRL)) begin // see RULE_09
        manual_sequence_control_out <= {1'b0, cmd_data[6:0]};   // see RULE_11
      end
      if (page0_hit(cmd_addr, ADDR_AUTO_SEQUENCE_CTRL)) begin
        auto_sequence_control_out <= cmd_data & 8'h8f;          // see RULE_03
      end
      if (page0_hit(cmd_addr, ADDR_AUXILIARY_CONFIG)) begin
        auxiliary_configuration_out <= cmd_data & 8'h0e;
      end
      if (page0_hit(cmd_addr, ADDR_AUTO_SCAN_MASK)) begin
        auto_scan_channel_mask_out <= cmd_data;
      end
      if (page0_hit(cmd_addr, ADDR_RANGE_PAIR_A)) begin
        range_select_pair_a_out <= cmd_data & 8'h77;
      end
      if (page0_hit(cmd_addr, ADDR_RANGE_PAIR_B)) begin
        range_select_pair_b_out <= cmd_data & 8'h77;
      end
    end
  end

  // the page register answers on both pages so software can get back
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_select_out <= RST_PAGE;                            // see RULE_07
    end else if (soft_reset) begin
      page_select_out <= RST_PAGE;                            // see RULE_14
    end else if (apply && cmd_addr == ADDR_PAGE_SELECT) begin
      page_select_out <= cmd_data[PAGE_BIT];                  // see RULE_08
    end
  end

  // power-down bypasses the deferred path: it acts as soon as the
  // completed frame has crossed, not at the next chip-select fall
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_down_out <= RST_POWER_DOWN;
    end else if (soft_reset) begin
      power_down_out <= RST_POWER_DOWN;
    end else if (tog_edge && !page_select_out
                 && cmd_addr == ADDR_POWER_DOWN_CONTROL) begin
      power_down_out <= cmd_data[POWER_DOWN_BIT];             // see RULE_06
    end
  end

  // last selected sequencing mode; a zero frame is a read and never
  // reaches this logic
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      auto_mode_out   <= 1'b0;
      seq_restart_out <= 1'b0;
    end else begin
      seq_restart_out <= page0_hit(cmd_addr, ADDR_AUTO_SEQUENCE_CTRL)
                         && cmd_data[SEQ_RESTART_BIT];
      if (soft_reset) begin
        auto_mode_out <= 1'b0;
      end else if (page0_hit(cmd_addr, ADDR_AUTO_SEQUENCE_CTRL)) begin
        auto_mode_out <= 1'b1;
      end else if (page0_hit(cmd_addr, ADDR_MANUAL_SEQUENCE_CTRL)) begin
        auto_mode_out <= 1'b0;                                // see RULE_10
      end
    end
  end

  // read mux; the registers change at a chip-select fall, power-down once its frame has crossed, long
  // before the eighth serial clock fall samples this quasi-static word
  always_comb begin
    rd_data = 8'h00;
    if (in_shift[7:1] == ADDR_PAGE_SELECT) begin
      rd_data = {7'h00, page_select_out};
    end else if (!page_select_out) begin
      case (in_shift[7:1])
        ADDR_POWER_DOWN_CONTROL:   rd_data = {7'h00, power_down_out};
        ADDR_MANUAL_SEQUENCE_CTRL: rd_data = manual_sequence_control_out;
        ADDR_AUTO_SEQUENCE_CTRL:   rd_data = auto_sequence_control_out;
        ADDR_AUXILIARY_CONFIG:     rd_data = auxiliary_configuration_out;
        ADDR_AUTO_SCAN_MASK:       rd_data = auto_scan_channel_mask_out;
        ADDR_RANGE_PAIR_A:         rd_data = range_select_pair_a_out;
        ADDR_RANGE_PAIR_B:         rd_data = range_select_pair_b_out;
        default:                   rd_data = 8'h00;
      endcase
    end
  end

  // ---------------- checks ----------------
  a_apply_at_fall: assert property ( // see RULE_05
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    apply && !page_select_out
    && cmd_addr == ADDR_MANUAL_SEQUENCE_CTRL
    |=> manual_sequence_control_out == {1'b0, $past(cmd_data[6:0])})
    else $error("manual write not applied at chip-select fall");

  a_no_early_apply: assert property ( // see RULE_05
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !cs_fall |=> $stable(auxiliary_configuration_out)
                 && $stable(range_select_pair_a_out))
    else $error("register changed without a chip-select fall");

  a_pd_immediate: assert property ( // see RULE_06
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    tog_edge && !page_select_out && !soft_reset
    && cmd_addr == ADDR_POWER_DOWN_CONTROL
    |=> power_down_out == $past(cmd_data[POWER_DOWN_BIT]))
    else $error("power-down not taken on frame end");

  a_page_select: assert property ( // see RULE_08
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    apply && !soft_reset && cmd_addr == ADDR_PAGE_SELECT
    && cmd_data == 8'h01 |=> page_select_out)
    else $error("page 1 not selected");

  a_page1_block: assert property ( // see RULE_07
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    page_select_out && apply && cmd_addr == ADDR_MANUAL_SEQUENCE_CTRL
    |=> $stable(manual_sequence_control_out))
    else $error("page-0 register written while on page 1");

  a_soft_reset: assert property ( // see RULE_14
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    soft_reset |=> auxiliary_configuration_out == RST_AUXILIARY_CONFIG
                   && !page_select_out && !auto_mode_out)
    else $error("soft reset did not restore defaults");

  a_zero_frame: assert property ( // see RULE_10
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    cs_fall && cmd_word == 16'h0000 && !pending
    |=> $stable(auto_mode_out) && $stable(manual_sequence_control_out))
    else $error("zero frame changed configuration");

  a_oe_release: assert property ( // see RULE_13
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    cs_n_in || fall_cnt == 5'(FRAME_BITS) |-> !dout_oe_out)
    else $error("output not released after 16 bits");

  a_rd_first_bit: assert property ( // see RULE_04
    @(negedge sclk_in) disable iff (!frame_rst_n)
    fall_cnt == RD_LOAD_EDGE && in_shift[0] == RW_READ
    |=> dout_out == $past(rd_data[7]) && dout_oe_out)
    else $error("read data msb not presented");

  a_page1_ignore: assert property ( // see RULE_09
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    page_select_out && apply && cmd_addr != ADDR_PAGE_SELECT
    |=> $stable(auxiliary_configuration_out)
        && $stable(auto_scan_channel_mask_out)
        && $stable(range_select_pair_b_out) && page_select_out)
    else $error("page-1 write reached a page-0 register");

  a_range_mask: assert property ( // see RULE_03
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    apply && !page_select_out && cmd_addr == ADDR_RANGE_PAIR_B
    |=> range_select_pair_b_out == ($past(cmd_data) & 8'h77))
    else $error("range pair write not stored with fixed zero bits");

  a_frame_capture: assert property ( // see RULE_12
    @(posedge sclk_in) disable iff (!rst_n_in)
    frame_rst_n && rise_cnt == LAST_EDGE
    |=> cmd_word == {$past(in_shift), $past(din_in)})
    else $error("command word not captured from the input bits");

  a_read_no_toggle: assert property ( // see RULE_04
    @(posedge sclk_in) disable iff (!rst_n_in)
    frame_rst_n && rise_cnt == LAST_EDGE
    && in_shift[ADDR_LSB-2] == RW_READ |=> $stable(wr_toggle))
    else $error("read frame handed over as a write");

  a_write_toggle: assert property ( // see RULE_15
    @(posedge sclk_in) disable iff (!rst_n_in)
    frame_rst_n && rise_cnt == LAST_EDGE
    && in_shift[ADDR_LSB-2] == RW_WRITE |=> $changed(wr_toggle))
    else $error("write frame not handed to the register side");

  c_read_frame: cover property (
    @(negedge sclk_in) disable iff (!frame_rst_n)
    fall_cnt == RD_LOAD_EDGE && in_shift[0] == RW_READ);
  c_manual_write: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    apply && !page_select_out
    && cmd_addr == ADDR_MANUAL_SEQUENCE_CTRL);
  c_page_switch: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(page_select_out));
  c_power_down: cover property (
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(power_down_out));

endmodule // adc_spi_register_access
`default_nettype wire

/* File: adc_spi_regs_pkg.sv */
`default_nettype none
package adc_spi_regs_pkg;
  // command word layout
  localparam int FRAME_BITS   = 16;
  localparam int ADDR_MSB     = 15;
  localparam int ADDR_LSB     = 9;
  localparam int RW_BIT       = 8;
  localparam int DATA_MSB     = 7;
  localparam int DATA_LSB     = 0;
  localparam logic RW_WRITE   = 1'b1;
  localparam logic RW_READ    = 1'b0;

  // register offsets
  localparam logic [6:0] ADDR_DEVICE_SOFT_RESET    = 7'h01;
  localparam logic [6:0] ADDR_POWER_DOWN_CONTROL   = 7'h02;
  localparam logic [6:0] ADDR_MANUAL_SEQUENCE_CTRL = 7'h04;
  localparam logic [6:0] ADDR_AUTO_SEQUENCE_CTRL   = 7'h05;
  localparam logic [6:0] ADDR_AUXILIARY_CONFIG     = 7'h06;
  localparam logic [6:0] ADDR_AUTO_SCAN_MASK       = 7'h0c;
  localparam logic [6:0] ADDR_RANGE_PAIR_A         = 7'h10;
  localparam logic [6:0] ADDR_RANGE_PAIR_B         = 7'h11;
  localparam logic [6:0] ADDR_PAGE_SELECT          = 7'h7f;

  // reset values
  localparam logic [7:0] RST_MANUAL_SEQUENCE_CTRL = 8'h00;
  localparam logic [7:0] RST_AUTO_SEQUENCE_CTRL   = 8'h00;
  localparam logic [7:0] RST_AUXILIARY_CONFIG     = 8'h08;
  localparam logic [7:0] RST_AUTO_SCAN_MASK       = 8'h00;
  localparam logic [7:0] RST_RANGE_PAIR           = 8'h11;
  localparam logic       RST_PAGE                 = 1'b0;
  localparam logic       RST_POWER_DOWN           = 1'b0;

  // field positions
  localparam int SOFT_RESET_BIT  = 0;
  localparam int POWER_DOWN_BIT  = 0;
  localparam int PAGE_BIT        = 0;
  localparam int SEQ_RESTART_BIT = 7;
  localparam int MAN_CHAN_MSB    = 6;
  localparam int MAN_CHAN_LSB    = 4;
  localparam int MAN_RANGE_MSB   = 3;
  localparam int MAN_RANGE_LSB   = 1;
  localparam int MAN_TEMP_BIT    = 0;

  // falling-edge index that loads the first read bit
  localparam logic [4:0] RD_LOAD_EDGE = 5'd7;
  localparam logic [4:0] LAST_EDGE    = 5'd15;
endpackage
`default_nettype wire

/* File: adc_spi_regs_pkg_note_placeholder_removed.sv */
`default_nettype none
`default_nettype wire

/* File: spi_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output var  logic sclk_out,
  output var  logic cs_n_out,
  output var  logic din_out,
  input  wire logic dout_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  // one whole frame; sclk parks low outside frames, 15 ns period inside
  task automatic frame(input logic [15:0] word, output logic [7:0] rd);
    rd = 8'h00;
    cs_n_out <= 1'b0;
    // off the reference grid so the two clocks never share an edge
    #21.3;
    for (int i = 15; i >= 0; i--) begin
      din_out <= word[i];
      #7.5 sclk_out <= 1'b1;
      if (i < 8) rd = {rd[6:0], dout_in};
      #7.5 sclk_out <= 1'b0;
    end
    // released line must not keep the last bit
    #20 din_out <= ~din_out;
    cs_n_out <= 1'b1;
    #58.7;
  endtask
endmodule // spi_host_model
`default_nettype wire

/* File: test_adc_spi_register_access.sv */
`timescale 1ns/100ps
`default_nettype none
module test_adc_spi_register_access;
  import adc_spi_regs_pkg::*;
  logic       ref_clk_in;
  logic       rst_n_in;
  logic       sclk, cs_n, din, dout, dout_oe;
  logic       dout_line;
  logic [7:0] man, auto_r, aux, mask, rng_a, rng_b;
  logic       page, pd, auto_md, restart;
  logic [7:0] rd;
  int         num_errors;
  int         checks;
  int         pulses;

  adc_spi_register_access dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
    .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
    .manual_sequence_control_out(man), .auto_sequence_control_out(auto_r),
    .auxiliary_configuration_out(aux), .auto_scan_channel_mask_out(mask),
    .range_select_pair_a_out(rng_a), .range_select_pair_b_out(rng_b),
    .page_select_out(page), .power_down_out(pd), .auto_mode_out(auto_md),
    .seq_restart_out(restart));

  // an undriven line floats to its pull-up level
  assign dout_line = dout_oe ? dout : 1'b1;

  spi_host_model host (
    .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout_line));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    if (restart === 1'b1) pulses <= pulses + 1;
  end

  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame({a, RW_WRITE, d}, rd);
  endtask

  task automatic rr(input logic [6:0] a, input logic [7:0] exp);
    host.frame({a, RW_READ, 8'ha5}, rd);
    check8(rd, exp);
  endtask

  task automatic nop();
    host.frame(16'h0000, rd);
    check8(rd, 8'h00);
  endtask

  task automatic t_defaults();
    check8(aux, 8'h08);
    check8(rng_b, 8'h11);
    check8({7'h00, page}, 8'h00);
    rr(7'h01, 8'h00);
    rr(7'h03, 8'h00);
    rr(7'h04, 8'h00);
    rr(7'h05, 8'h00);
    rr(7'h06, 8'h08);
    rr(7'h0c, 8'h00);
    rr(7'h10, 8'h11);
    rr(7'h11, 8'h11);
    rr(7'h7f, 8'h00);
  endtask

  task automatic t_deferred();
    wr(7'h04, 8'h35);
    idle(10);
    check8(man, 8'h00);
    rr(7'h04, 8'h35);
    check8({5'h00, man[6:4]}, 8'h03);
    check8({5'h00, man[3:1]}, 8'h02);
    check8({7'h00, man[0]}, 8'h01);
    check8({7'h00, auto_md}, 8'h00);
    check8({7'h00, dout_oe}, 8'h00);
  endtask

  task automatic t_masks();
    wr(7'h06, 8'hff);
    rr(7'h06, 8'h0e);
    wr(7'h0c, 8'ha5);
    rr(7'h0c, 8'ha5);
    wr(7'h10, 8'hff);
    rr(7'h10, 8'h77);
    wr(7'h11, 8'hab);
    rr(7'h11, 8'h23);
    check8(aux, 8'h0e);
    check8(mask, 8'ha5);
    check8(rng_a, 8'h77);
  endtask

  task automatic t_auto();
    int base;
    nop();
    check8(man, 8'h35);
    base = pulses;
    wr(7'h05, 8'h8e);
    nop();
    idle(4);
    check8({4'h0, auto_r[3:0]}, 8'h0e);
    check8({7'h00, auto_md}, 8'h01);
    check8(8'(pulses - base), 8'h01);
    nop();
    check8({7'h00, auto_md}, 8'h01);
  endtask

  task automatic t_power();
    wr(7'h02, 8'h01);
    idle(8);
    check8({7'h00, pd}, 8'h01);
    check8({7'h00, cs_n}, 8'h01);
    wr(7'h02, 8'h00);
    idle(8);
    check8({7'h00, pd}, 8'h00);
  endtask

  task automatic t_page();
    wr(7'h7f, 8'h01);
    nop();
    check8({7'h00, page}, 8'h01);
    rr(7'h04, 8'h00);
    wr(7'h04, 8'h00);
    rr(7'h7f, 8'h01);
    wr(7'h7f, 8'h00);
    nop();
    check8({7'h00, page}, 8'h00);
    rr(7'h04, 8'h35);
  endtask

  task automatic t_soft();
    wr(7'h01, 8'h01);
    nop();
    idle(4);
    check8(man, 8'h00);
    check8(aux, 8'h08);
    check8(mask, 8'h00);
    check8(rng_a, 8'h11);
    check8({7'h00, auto_md}, 8'h00);
  endtask

  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rst_n_in = 1'b0;
    num_errors = 0;
    checks = 0;
    idle(2);
    rst_n_in <= 1'b1;
    idle(4);
    t_defaults();
    t_deferred();
    t_masks();
    t_auto();
    t_power();
    t_page();
    t_soft();
    tally_and_finish();
  end
endmodule // test_adc_spi_register_access
`default_nettype wire
